// File: common/sbs_pkg.sv
`default_nettype none
package sbs_pkg;
	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] ADR_SIZE = 8'h00;
	localparam logic [7:0] ADR_ENABLE = 8'h04;
	localparam logic [7:0] ADR_BASE_LO = 8'h08;
	localparam logic [7:0] ADR_BASE_HI = 8'h0C;
	localparam logic [7:0] ADR_CTRL = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;

	localparam int NUM_BLOCKS = 8;
	localparam int CODE_W = 4;
	localparam int BASE_W = 8;
	localparam int BASE_LSB = 24;
	localparam int WORD_LSB = 3;
	localparam int BANK_BITS = 2;

	// Field positions
	localparam int CTRL_INHIBIT_BIT = 0;
	localparam int CTRL_SCRUB_BIT = 1;
	localparam int STAT_REFRESH_BIT = 0;
	localparam int STAT_MASK_LSB = 8;

	// Reset values
	localparam logic [31:0] SIZE_RST = 32'h0000_0000;
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [31:0] BASE_RST = 32'h0000_0000;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// Refresh interval: a longest time, so the count rounds down
	localparam int CLK_NS = 10;
	localparam int REFRESH_NS = 7800;
	localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;

	// Size codes
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_32M_X16 = 4'h1;
	localparam logic [3:0] CODE_64M_X8 = 4'h2;
	localparam logic [3:0] CODE_64M_X16 = 4'h3;
	localparam logic [3:0] CODE_128M_X4 = 4'h4;
	localparam logic [3:0] CODE_128M_X8 = 4'h5;
	localparam logic [3:0] CODE_128M_X16 = 4'h6;
	localparam logic [3:0] CODE_256M_X4 = 4'h7;
	localparam logic [3:0] CODE_256M_X8 = 4'h8;
	localparam logic [3:0] CODE_512M_X4 = 4'h9;

	typedef struct packed {
		logic ok;
		logic [3:0] row_bits;
		logic [3:0] col_bits;
	} sbs_geom_t;

	typedef struct packed {
		logic [12:0] row;
		logic [1:0] bank;
		logic [10:0] col;
	} sbs_sdr_addr_t;
endpackage
`default_nettype wire

// File: design/sbs_top.sv
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Size code 1..9 selects block geometry from 32MB up to 512MB.
// - Block bytes are locations times eight; each location is 64 bits.
// - Locations are two to rows times two to columns times four banks.
// - Codes 4 and 5 decode alike, as do codes 2 and 3.
// - Refresh only happens while refresh inhibit is clear.
// - Size codes reset to zero and drive decoding and translation.
// - Only blocks with non-zero size join scrubbing when enabled.
module sbs_top (
	input wire logic clk_i, // Bus clock, 100 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic wb_we_i, // Wishbone write
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic acc_valid_i, // Memory access request
	input wire logic [31:0] acc_addr_i, // Memory access address
	output logic hit_o, // Access lands in an enabled block
	output logic miss_o, // Access lands in no enabled block
	output logic [2:0] hit_block_o, // Index of the hit block
	output sbs_pkg::sbs_sdr_addr_t sdr_addr_o, // Row, bank, column
	output logic refresh_o, // Refresh request pulse
	output logic [7:0] scrub_mask_o // Blocks taking part in scrubbing
);
	import sbs_pkg::*;

	function automatic sbs_geom_t geom_of(input logic [3:0] code);
		sbs_geom_t g;
		g = '{ok: 1'b1, row_bits: 4'd12, col_bits: 4'd8};
		unique case (code)
			CODE_32M_X16: g.col_bits = 4'd8;
			CODE_64M_X8, CODE_64M_X16: g.col_bits = 4'd9;
			CODE_128M_X4, CODE_128M_X8: g.col_bits = 4'd10;
			CODE_128M_X16: begin
				g.row_bits = 4'd13;
				g.col_bits = 4'd9;
			end
			CODE_256M_X4, CODE_256M_X8: begin
				g.row_bits = 4'd13;
				g.col_bits = 4'd10;
			end
			CODE_512M_X4: begin
				g.row_bits = 4'd13;
				g.col_bits = 4'd11;
			end
			default: g.ok = 1'b0;
		endcase
		return g;
	endfunction

	// Log2 of block bytes: rows + columns + banks + bytes per word
	function automatic logic [4:0] size_lg(input sbs_geom_t g);
		return 5'(g.row_bits) + 5'(g.col_bits) + 5'(BANK_BITS) +
			5'(WORD_LSB);
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] size_r;
	logic [7:0] enable_r;
	logic [31:0] base_lo_r;
	logic [31:0] base_hi_r;
	logic inhibit_r;
	logic scrub_en_r;
	logic refresh_seen_r;
	logic [9:0] refresh_cnt_r;
	logic [31:0] rd_nxt;
	logic wb_req;
	logic wr_take;
	logic [63:0] base_all;
	logic [7:0] hit_vec;
	logic [7:0] nz_vec;
	logic [2:0] blk_nxt;
	sbs_sdr_addr_t sdr_nxt;
	sbs_geom_t hit_geom;

	assign wb_req = wb_cyc_i && wb_stb_i;
	// Writes land at the edge where the master samples ack high
	assign wr_take = wb_req && wb_we_i && wb_ack_o;
	assign base_all = {base_hi_r, base_lo_r};

	// Bus answer: one wait state, ack for one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= rd_nxt;
		end
	end

	always_comb begin
		unique case (wb_adr_i)
			ADR_SIZE: rd_nxt = size_r;
			ADR_ENABLE: rd_nxt = {24'h00_0000, enable_r};
			ADR_BASE_LO: rd_nxt = base_lo_r;
			ADR_BASE_HI: rd_nxt = base_hi_r;
			ADR_CTRL: rd_nxt = {30'h0000_0000, scrub_en_r, inhibit_r};
			ADR_STATUS: rd_nxt = {16'h0000, scrub_mask_o, 7'h00,
				refresh_seen_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Geometry registers; size codes come out of reset as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			size_r <= SIZE_RST;
			enable_r <= ENABLE_RST;
			base_lo_r <= BASE_RST;
			base_hi_r <= BASE_RST;
		end else if (wr_take) begin
			unique case (wb_adr_i)
				ADR_SIZE: size_r <= lane_merge(size_r, wb_dat_i, wb_sel_i);
				ADR_ENABLE: if (wb_sel_i[0]) enable_r <= wb_dat_i[7:0];
				ADR_BASE_LO:
					base_lo_r <= lane_merge(base_lo_r, wb_dat_i, wb_sel_i);
				ADR_BASE_HI:
					base_hi_r <= lane_merge(base_hi_r, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{scrub_en_r, inhibit_r} <= CTRL_RST;
		end else if (wr_take && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
			inhibit_r <= wb_dat_i[CTRL_INHIBIT_BIT];
			scrub_en_r <= wb_dat_i[CTRL_SCRUB_BIT];
		end
	end

	// Refresh timer keeps running while inhibited so the interval is
	// not stretched, but no request goes out
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			refresh_cnt_r <= 10'd0;
			refresh_o <= 1'b0;
		end else begin
			if (refresh_cnt_r == 10'(REFRESH_CYC - 1)) begin
				refresh_cnt_r <= 10'd0;
			end else begin
				refresh_cnt_r <= refresh_cnt_r + 10'd1;
			end
			refresh_o <= (refresh_cnt_r == 10'(REFRESH_CYC - 1)) &&
				!inhibit_r;
		end
	end

	// Sticky flag lets software see that a refresh has passed;
	// a new refresh beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			refresh_seen_r <= 1'b0;
		end else if (refresh_o) begin
			refresh_seen_r <= 1'b1;
		end else if (wr_take && wb_adr_i == ADR_STATUS && wb_sel_i[0] &&
			wb_dat_i[STAT_REFRESH_BIT]) begin
			refresh_seen_r <= 1'b0;
		end
	end

	// Per-block address match
	for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_blk
		sbs_geom_t geo;
		logic [31:0] base_bytes;
		logic [4:0] lg;
		assign geo = geom_of(size_r[CODE_W*g +: CODE_W]);
		assign lg = size_lg(geo);
		assign base_bytes = {base_all[BASE_W*g +: BASE_W], 24'h00_0000};
		assign nz_vec[g] = size_r[CODE_W*g +: CODE_W] != CODE_NONE;
		assign hit_vec[g] = enable_r[g] && geo.ok &&
			(((acc_addr_i ^ base_bytes) >> lg) == 32'h0000_0000);
	end

	// Lowest block wins if software overlaps two blocks
	always_comb begin
		blk_nxt = 3'd0;
		for (int i = NUM_BLOCKS - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				blk_nxt = 3'(i);
			end
		end
	end

	// Bus address to row, bank and column for the hit block
	always_comb begin
		logic [31:0] word;
		logic [31:0] col_t;
		logic [31:0] bank_t;
		logic [31:0] row_t;
		word = 32'h0000_0000;
		col_t = 32'h0000_0000;
		bank_t = 32'h0000_0000;
		row_t = 32'h0000_0000;
		hit_geom = geom_of(size_r[CODE_W*blk_nxt +: CODE_W]);
		word = {3'b000, acc_addr_i[31:WORD_LSB]};
		col_t = word & ((32'h0000_0001 << hit_geom.col_bits) - 32'h1);
		bank_t = (word >> hit_geom.col_bits) & 32'h0000_0003;
		row_t = (word >> (hit_geom.col_bits + 4'd2)) &
			((32'h0000_0001 << hit_geom.row_bits) - 32'h1);
		sdr_nxt.col = col_t[10:0];
		sdr_nxt.bank = bank_t[1:0];
		sdr_nxt.row = row_t[12:0];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hit_o <= 1'b0;
			miss_o <= 1'b0;
			hit_block_o <= 3'd0;
			sdr_addr_o <= '0;
		end else begin
			hit_o <= acc_valid_i && (|hit_vec);
			miss_o <= acc_valid_i && !(|hit_vec);
			if (acc_valid_i && (|hit_vec)) begin
				hit_block_o <= blk_nxt;
				sdr_addr_o <= sdr_nxt;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scrub_mask_o <= 8'h00;
		end else begin
			scrub_mask_o <= nz_vec & {8{scrub_en_r}};
		end
	end

	property p_size_reset;
		@(posedge clk_i) rst_i |=> size_r == 32'h0000_0000 && !hit_o;
	endproperty
	a_size_reset: assert property (p_size_reset)
		else $error("size codes not zero after reset");

	property p_code9_span;
		@(posedge clk_i) disable iff (rst_i)
		acc_valid_i && enable_r[0] && size_r[3:0] == 4'h9 &&
		base_lo_r[7:0] == 8'h00 && acc_addr_i[31:29] == 3'b000
		|=> hit_o && hit_block_o == 3'd0;
	endproperty
	a_code9_span: assert property (p_code9_span)
		else $error("512MB block failed to claim its span");

	property p_code1_col;
		@(posedge clk_i) disable iff (rst_i)
		acc_valid_i && hit_vec == 8'h01 && size_r[3:0] == 4'h1
		|=> sdr_addr_o.col == 11'($past(acc_addr_i[10:3])) &&
		sdr_addr_o.bank == $past(acc_addr_i[12:11]) &&
		sdr_addr_o.row == 13'($past(acc_addr_i[24:13]));
	endproperty
	a_code1_col: assert property (p_code1_col)
		else $error("32MB block translation wrong");

	property p_code1_edge;
		@(posedge clk_i) disable iff (rst_i)
		acc_valid_i && enable_r == 8'h01 && size_r[3:0] == 4'h1 &&
		base_lo_r[7:0] == 8'h00 && acc_addr_i == 32'h0200_0000
		|=> miss_o && !hit_o;
	endproperty
	a_code1_edge: assert property (p_code1_edge)
		else $error("32MB block claimed beyond its byte size");

	property p_alias;
		@(posedge clk_i) disable iff (rst_i)
		acc_valid_i && hit_vec == 8'h01 &&
		(size_r[3:0] == CODE_128M_X4 || size_r[3:0] == CODE_128M_X8)
		|=> sdr_addr_o.col == 11'($past(acc_addr_i[12:3])) &&
		sdr_addr_o.bank == $past(acc_addr_i[14:13]) &&
		sdr_addr_o.row == 13'($past(acc_addr_i[26:15]));
	endproperty
	a_alias: assert property (p_alias)
		else $error("aliased size codes decode differently");

	property p_refresh_gate;
		@(posedge clk_i) disable iff (rst_i)
		refresh_o |-> !$past(inhibit_r);
	endproperty
	a_refresh_gate: assert property (p_refresh_gate)
		else $error("refresh issued while inhibited");

	property p_scrub;
		@(posedge clk_i) disable iff (rst_i)
		size_r[15:12] == CODE_NONE || !scrub_en_r |=> !scrub_mask_o[3];
	endproperty
	a_scrub: assert property (p_scrub)
		else $error("scrub set holds a zero-size block");

	property p_scrub_on;
		@(posedge clk_i) disable iff (rst_i)
		size_r[15:12] != CODE_NONE && scrub_en_r |=> scrub_mask_o[3];
	endproperty
	a_scrub_on: assert property (p_scrub_on)
		else $error("sized block left out of scrubbing");

	property p_claim;
		@(posedge clk_i) disable iff (rst_i)
		hit_o |-> ($past(enable_r & nz_vec) != 8'h00) && !miss_o;
	endproperty
	a_claim: assert property (p_claim)
		else $error("access claimed with no enabled sized block");
endmodule
`default_nettype wire

// File: tb/sbs_sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: keeps the last decoded access and counts refreshes
module sbs_sdram_model (
	input wire logic clk_i, // Bus clock
	input wire logic rst_i, // Reset
	input wire logic hit_i, // Access hit
	input wire logic [2:0] blk_i, // Hit block
	input wire sbs_pkg::sbs_sdr_addr_t adr_i, // Row, bank, column
	input wire logic refresh_i, // Refresh pulse
	output logic [2:0] blk_o, // Last block
	output logic [31:0] adr_o, // Last address
	output logic [15:0] ref_o // Refreshes seen
);
	import sbs_pkg::*;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blk_o <= 3'h0;
			adr_o <= 32'h0000_0000;
		end else if (hit_i) begin
			blk_o <= blk_i;
			adr_o <= {6'h0, adr_i};
		end
	end
	// Rows only hold data while refreshes keep coming
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ref_o <= 16'h0000;
		else if (refresh_i)
			ref_o <= ref_o + 16'h0001;
	end
endmodule
`default_nettype wire

// File: tb/sbs_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sbs_top_bench;
	import sbs_pkg::*;
	logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, av = 0;
	logic [7:0] adr = 0;
	logic [3:0] sel = 0;
	logic [31:0] dat = 0, aa = 0, rd, m_adr, wb_dat_o;
	logic wb_ack_o, hit_o, miss_o, refresh_o;
	logic [2:0] hit_block_o, m_blk;
	logic [7:0] scrub_mask_o;
	logic [15:0] m_ref, r0;
	sbs_sdr_addr_t sdr;
	int mismatches = 0, check_count = 0, n, lg;
	int rw[1:9] = '{12, 12, 12, 12, 12, 13, 13, 13, 13};
	int cl[1:9] = '{8, 9, 9, 10, 10, 9, 10, 10, 11};
	sbs_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.acc_valid_i(av), .acc_addr_i(aa), .hit_o(hit_o), .miss_o(miss_o),
		.hit_block_o(hit_block_o), .sdr_addr_o(sdr),
		.refresh_o(refresh_o), .scrub_mask_o(scrub_mask_o));
	sbs_sdram_model mem (.clk_i(clk_i), .rst_i(rst_i), .hit_i(hit_o),
		.blk_i(hit_block_o), .adr_i(sdr), .refresh_i(refresh_o),
		.blk_o(m_blk), .adr_o(m_adr), .ref_o(m_ref));
	initial begin
		forever #(CLK_NS / 2) clk_i = ~clk_i;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
		end
	endtask
	// Waits on ack with a bound so a dead slave cannot hang the run
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		chk(n < 20, 1);
		cyc <= 0;
		stb <= 0;
		we <= 0;
	endtask
	task acc(input logic [31:0] a, input logic [1:0] hm,
		input logic [31:0] sa);
		@(posedge clk_i);
		av <= 1;
		aa <= a;
		@(posedge clk_i);
		av <= 0;
		@(posedge clk_i);
		chk({30'h0, hit_o, miss_o}, {30'h0, hm});
		if (hm[1]) begin
			@(posedge clk_i);
			chk(m_adr, sa);
		end
	endtask
	task wt;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (refresh_o !== 1'b1 && n < 2000);
		chk(n < 2000, 1);
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#400000;
		mismatches++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 7; i++) begin
			bus(0, 8'(i * 4), 0);
			chk(rd, 0);
		end
		$display("test reset done");
		// Speed attributes live outside this block; nothing to set
		bus(1, ADR_CTRL, 0);
		bus(1, ADR_ENABLE, 32'h0000_0001);
		for (int c = 9; c >= 1; c--) begin
			lg = rw[c] + cl[c] + 5;
			bus(1, ADR_SIZE, c);
			wt;
			acc((1 << lg) - 8, 2'b10, (((1 << rw[c]) - 1) << 13) | 32'h1800
				| ((1 << cl[c]) - 1));
			acc(1 << lg, 2'b01, 0);
			if (c <= 3) begin
				acc(0, 2'b10, 0);
				acc(c == 1 ? 32'h0000_1000 : 32'h0000_2000, 2'b10,
					32'h0000_1000);
			end
		end
		$display("test size codes done");
		bus(1, ADR_SIZE, 32'h0000_000A);
		acc(0, 2'b01, 0);
		bus(1, ADR_SIZE, 0);
		acc(0, 2'b01, 0);
		bus(1, ADR_SIZE, 1);
		bus(1, ADR_ENABLE, 0);
		acc(0, 2'b01, 0);
		wt;
		bus(1, ADR_SIZE, 32'h0000_3000);
		bus(1, ADR_ENABLE, 32'h0000_0008);
		bus(1, ADR_BASE_LO, 32'h0400_0000);
		wt;
		acc(32'h0400_0008, 2'b10, 1);
		chk(m_blk, 3);
		acc(32'h0800_0000, 2'b01, 0);
		acc(0, 2'b01, 0);
		$display("test decode done");
		bus(1, ADR_CTRL, 2);
		bus(0, ADR_STATUS, 0);
		chk(rd[15:8], 8'h08);
		chk(scrub_mask_o, 8'h08);
		bus(1, ADR_CTRL, 0);
		bus(0, ADR_STATUS, 0);
		chk(scrub_mask_o, 0);
		$display("test scrub done");
		wt;
		wt;
		chk(n, 780);
		bus(0, ADR_STATUS, 0);
		chk(rd[0], 1);
		bus(1, ADR_CTRL, 1);
		repeat (2) @(posedge clk_i);
		r0 = m_ref;
		repeat (1600) @(posedge clk_i);
		chk(m_ref - r0, 0);
		$display("test refresh done");
		test_done;
	end
endmodule
`default_nettype wire
